// [reset_strap_latch.sv]
// reset-time strap capture and configuration decode
`timescale 1ns/1ns

// How it works
// R1 - address pins are inputs during host reset; levels captured when reset releases
// R2 - after reset the address pins drive SDRAM row/column addresses
// R3 - undriven strap pins read as one via internal pull-up
// R4 - strap bit 8 zero enables manufacturer test mode
// R5 - strap bit 7 zero gives pin group to PCI arbiter, one to peripheral port
// R6 - strap bit 6 one refuses PCI access until host initialises control registers
// R7 - strap bit 6 zero is blank-ROM mode, PCI allowed before initialisation
// R8 - class code B40001h when strap bit 3 one, else 0E0001h
// R9 - strap bit 2 zero enables output-hold test mode
// R10 - ROM width strap: 11 byte, 01 word, 10 dword, 00 reserved
// R11 - configuration holds until the next host reset cycle
module reset_strap_latch
    import strap_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic host_side_reset_n_i,
    input wire logic [MA_WIDTH-1:0] memory_address_pins_i,
    input wire logic [MA_WIDTH-1:0] sdram_addr_i,
    input wire logic control_status_regs_init_i,
    input wire logic pci_access_req_i,
    output logic [MA_WIDTH-1:0] memory_address_pins_o,
    output logic [MA_WIDTH-1:0] memory_address_pins_oe_o,
    output strap_cfg_t cfg_o,
    output logic pci_access_allow_o,
    output logic pci_access_refuse_o,
    output logic cfg_valid_o
);

    logic [MA_WIDTH-1:0] pins_s;
    logic host_rst_n_s;
    logic capture_w;
    logic run_w;
    logic [MA_WIDTH-1:0] strap_r;
    strap_state_t state_r;
    strap_state_t state_nxt;
    logic init_done_r;
    strap_cfg_t cfg_nxt;
    rom_width_t romw;
    logic allow_nxt;

    // ==========================================================
    // input synchronisation
    // R3 strap flops idle high
    strap_sync #(
        .WIDTH(MA_WIDTH),
        .IDLE_VAL(1'b1)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i(memory_address_pins_i),
        .sync_o(pins_s)
    );

    // ==========================================================
    // host reset synchronisation
    // R1 idles in host reset
    strap_sync #(
        .WIDTH(1),
        .IDLE_VAL(1'b0)
    ) u_host_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i(host_side_reset_n_i),
        .sync_o(host_rst_n_s)
    );

    // ==========================================================
    // capture and run strobes
    // R1 capture on release
    assign capture_w = (state_r == ST_RESET) && host_rst_n_s;
    assign run_w = (state_r == ST_RUN);

    // ==========================================================
    // sequencing: reset, one sample cycle at release, run
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RESET: begin
                if (host_rst_n_s) begin
                    state_nxt = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                state_nxt = host_rst_n_s ? ST_RUN : ST_RESET;
            end
            ST_RUN: begin
                if (!host_rst_n_s) begin
                    state_nxt = ST_RESET;
                end
            end
            default: begin
                state_nxt = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // strap capture
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            // R3 pull-up default
            strap_r <= STRAP_RESET_VAL;
        // R1 capture at release
        end else if (capture_w) begin
            strap_r <= pins_s;
        end
        // R11 otherwise held
    end

    // ==========================================================
    // configuration decode
    always_comb begin
        // R10 width decode
        case (strap_r[BIT_ROM_WIDTH_HI:BIT_ROM_WIDTH_LO])
            ROMW_CODE_8: romw = ROM_W8;
            ROMW_CODE_16: romw = ROM_W16;
            ROMW_CODE_32: romw = ROM_W32;
            default: romw = ROM_WRSV;
        endcase
        // R4 manufacturer test
        cfg_nxt.mfg_test_en = ~strap_r[BIT_MFG_TEST_N];
        // R5 arbiter or peripheral port
        cfg_nxt.arbiter_sel = ~strap_r[BIT_XBUS_SEL];
        // R7 blank rom mode
        cfg_nxt.blank_rom_mode = ~strap_r[BIT_NORMAL_ROM];
        cfg_nxt.rom_width = romw;
        // R8 class code select
        cfg_nxt.class_code = strap_r[BIT_CLASS_SEL] ? CLASS_CODE_ONE : CLASS_CODE_ZERO;
        // R9 output hold test
        cfg_nxt.ohold_test_en = ~strap_r[BIT_OHOLD_N];
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_o <= '0;
        end else begin
            // R11 follows held straps
            cfg_o <= cfg_nxt;
        end
    end

    // ==========================================================
    // configuration valid flag
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_valid_o <= 1'b0;
        end else begin
            // R1 low in reset
            cfg_valid_o <= run_w;
        end
    end

    // ==========================================================
    // pci access gating
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            init_done_r <= 1'b0;
        end else if (!run_w) begin
            init_done_r <= 1'b0;
        end else if (control_status_regs_init_i) begin
            init_done_r <= 1'b1;
        end
    end

    always_comb begin
        // R6 refuse until initialised
        // R7 blank rom accepts early
        allow_nxt = run_w && (init_done_r || !strap_r[BIT_NORMAL_ROM]);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pci_access_allow_o <= 1'b0;
        end else begin
            pci_access_allow_o <= allow_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pci_access_refuse_o <= 1'b0;
        end else begin
            // R6 refused request flag
            pci_access_refuse_o <= pci_access_req_i && !allow_nxt;
        end
    end

    // ==========================================================
    // address pin direction, one flop pair per pin
    genvar pi;
    generate
        for (pi = 0; pi < MA_WIDTH; pi = pi + 1) begin : g_pin
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    memory_address_pins_o[pi] <= 1'b0;
                    memory_address_pins_oe_o[pi] <= 1'b0;
                end else if (state_nxt == ST_RUN) begin
                    // R2 drive sdram address
                    memory_address_pins_o[pi] <= sdram_addr_i[pi];
                    memory_address_pins_oe_o[pi] <= 1'b1;
                end else begin
                    // R1 pins released as inputs
                    memory_address_pins_o[pi] <= 1'b0;
                    memory_address_pins_oe_o[pi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : reset_strap_latch

// [reset_strap_latch_chk.sv]
// checker: strap capture and decode assertions
`timescale 1ns/1ns
module reset_strap_latch_chk
    import strap_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic host_side_reset_n_i,
    input wire logic [MA_WIDTH-1:0] memory_address_pins_i,
    input wire logic [MA_WIDTH-1:0] sdram_addr_i,
    input wire logic control_status_regs_init_i,
    input wire logic pci_access_req_i,
    input wire logic [MA_WIDTH-1:0] memory_address_pins_o,
    input wire logic [MA_WIDTH-1:0] memory_address_pins_oe_o,
    input wire strap_cfg_t cfg_o,
    input wire logic pci_access_allow_o,
    input wire logic pci_access_refuse_o,
    input wire logic cfg_valid_o
);
    logic [MA_WIDTH-1:0] seen_r;
    rom_width_t w_exp;
    // ==========================================================
    // strap levels last seen in host reset
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seen_r <= STRAP_RESET_VAL;
        end else if (!host_side_reset_n_i) begin
            seen_r <= memory_address_pins_i;
        end
    end
    assign w_exp = seen_r[5:4] == ROMW_CODE_8 ? ROM_W8 : seen_r[5:4] == ROMW_CODE_16 ? ROM_W16 :
        seen_r[5:4] == ROMW_CODE_32 ? ROM_W32 : ROM_WRSV;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i || !host_side_reset_n_i);
    // ==========================================================
    // assertions
    property p_oe_off;
        disable iff (!arst_n_i) !host_side_reset_n_i [*4] |-> memory_address_pins_oe_o == '0;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pins driven in reset");
    property p_drive;
        cfg_valid_o |-> memory_address_pins_oe_o == '1 && memory_address_pins_o == $past(sdram_addr_i);
    endproperty
    a_drive: assert property (p_drive) else $error("address drive wrong");
    property p_mfg;
        cfg_valid_o |-> cfg_o.mfg_test_en == !seen_r[8];
    endproperty
    a_mfg: assert property (p_mfg) else $error("test mode wrong");
    property p_arb;
        cfg_valid_o |-> cfg_o.arbiter_sel == !seen_r[7];
    endproperty
    a_arb: assert property (p_arb) else $error("pin group wrong");
    property p_gate;
        $rose(cfg_valid_o) |-> pci_access_allow_o == !seen_r[6] && cfg_o.blank_rom_mode == !seen_r[6];
    endproperty
    a_gate: assert property (p_gate) else $error("pci gate wrong");
    property p_class;
        cfg_valid_o |-> cfg_o.class_code == (seen_r[3] ? CLASS_CODE_ONE : CLASS_CODE_ZERO);
    endproperty
    a_class: assert property (p_class) else $error("class code wrong");
    property p_width;
        cfg_valid_o |-> cfg_o.rom_width == w_exp;
    endproperty
    a_width: assert property (p_width) else $error("rom width wrong");
    property p_hold;
        cfg_valid_o |-> $stable(cfg_o);
    endproperty
    a_hold: assert property (p_hold) else $error("config moved");
    property p_ohold;
        cfg_valid_o |-> cfg_o.ohold_test_en == !seen_r[2];
    endproperty
    a_ohold: assert property (p_ohold) else $error("hold test mode wrong");
    property p_refuse;
        pci_access_refuse_o |-> $past(pci_access_req_i) && !pci_access_allow_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refuse flag wrong");
    property p_valid_off;
        disable iff (!arst_n_i) !host_side_reset_n_i [*5] |-> !cfg_valid_o && !pci_access_allow_o;
    endproperty
    a_valid_off: assert property (p_valid_off) else $error("valid in reset");
    c_run: cover property ($rose(cfg_valid_o));
    c_refuse: cover property (pci_access_refuse_o);
    c_allow: cover property ($rose(pci_access_allow_o));
endmodule : reset_strap_latch_chk
bind reset_strap_latch reset_strap_latch_chk chk_i (.clk_sys_i, .arst_n_i, .host_side_reset_n_i,
    .memory_address_pins_i, .sdram_addr_i, .control_status_regs_init_i, .pci_access_req_i,
    .memory_address_pins_o, .memory_address_pins_oe_o, .cfg_o, .pci_access_allow_o,
    .pci_access_refuse_o, .cfg_valid_o);

// [reset_strap_latch_test.sv]
// testbench: strap capture, decode and pci gating
`timescale 1ns/1ns
module reset_strap_latch_test;
    import strap_pkg::*;
    logic clk_sys_i = 0;
    logic arst_n_i = 0;
    logic hrst_n = 0;
    logic [12:0] pd = '0;
    logic [12:0] sdram = '0;
    logic init = 0;
    logic req = 0;
    logic [12:0] pins, drv, oe;
    strap_cfg_t cfg;
    logic allow, refuse, valid;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [12:0] tbl [4] = '{13'h0000, 13'h01fc, 13'h00a0, 13'h0150};
    always #4 clk_sys_i = ~clk_sys_i;
    strap_board brd (.pull_dn_i(pd), .drv_i(drv), .oe_i(oe), .pin_o(pins));
    reset_strap_latch dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .host_side_reset_n_i(hrst_n),
        .memory_address_pins_i(pins), .sdram_addr_i(sdram), .control_status_regs_init_i(init),
        .pci_access_req_i(req), .memory_address_pins_o(drv), .memory_address_pins_oe_o(oe),
        .cfg_o(cfg), .pci_access_allow_o(allow), .pci_access_refuse_o(refuse), .cfg_valid_o(valid));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    function strap_cfg_t exp_cfg(input logic [12:0] s);
        strap_cfg_t e;
        e.mfg_test_en = !s[8];
        e.arbiter_sel = !s[7];
        e.blank_rom_mode = !s[6];
        e.rom_width = s[5:4] == 2'h3 ? ROM_W8 : s[5:4] == 2'h1 ? ROM_W16 : s[5:4] == 2'h2 ? ROM_W32 : ROM_WRSV;
        e.class_code = s[3] ? 24'hb4_0001 : 24'h0e_0001;
        e.ohold_test_en = !s[2];
        return e;
    endfunction : exp_cfg
    task close_out;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task host_cycle(input logic [12:0] p);
        int n;
        hrst_n = 0;
        pd = p;
        repeat (6) @(posedge clk_sys_i);
        #1 chk("oe_reset", 32'(oe), 32'h0000_0000);
        hrst_n = 1;
        n = 0;
        while (valid !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        chk("valid", 32'(valid), 32'h0000_0001);
    endtask : host_cycle
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 arst_n_i = 1;
        foreach (tbl[i]) begin
            sdram = ~tbl[i];
            host_cycle(tbl[i]);
            chk("cfg", 32'(cfg), 32'(exp_cfg(~tbl[i])));
            chk("oe_run", 32'(oe), 32'(13'h1fff));
            chk("drive", 32'(pins), 32'(sdram));
            chk("allow", 32'(allow), 32'(tbl[i][6]));
            req = 1;
            repeat (2) @(posedge clk_sys_i);
            #1 chk("refuse", 32'(refuse), 32'(!tbl[i][6]));
            req = 0;
            init = 1;
            @(posedge clk_sys_i);
            #1 init = 0;
            repeat (3) @(posedge clk_sys_i);
            #1 chk("allow_init", 32'(allow), 32'h0000_0001);
            pd = ~tbl[i];
            sdram = tbl[i];
            repeat (3) @(posedge clk_sys_i);
            #1 chk("hold", 32'(cfg), 32'(exp_cfg(~tbl[i])));
            chk("drive_new", 32'(pins), 32'(sdram));
        end
        arst_n_i = 0;
        hrst_n = 0;
        @(posedge clk_sys_i);
        #1 chk("valid_arst", 32'(valid), 32'h0000_0000);
        arst_n_i = 1;
        repeat (4) begin
            @(posedge clk_sys_i);
            #1 chk("oe_arst", 32'(oe), 32'h0000_0000);
        end
        host_cycle(tbl[2]);
        chk("cfg_arst", 32'(cfg), 32'(exp_cfg(~tbl[2])));
        close_out();
    end
endmodule : reset_strap_latch_test

// [strap_board.sv]
// board straps: external pull-downs over internal pull-ups
`timescale 1ns/1ns
module strap_board
    import strap_pkg::*;
(
    input wire logic [MA_WIDTH-1:0] pull_dn_i,
    input wire logic [MA_WIDTH-1:0] drv_i,
    input wire logic [MA_WIDTH-1:0] oe_i,
    output logic [MA_WIDTH-1:0] pin_o
);
    assign pin_o = (oe_i & drv_i) | (~oe_i & ~pull_dn_i);
endmodule : strap_board

// [strap_pkg.sv]
// package: strap capture constants and configuration types
package strap_pkg;

    // ==========================================================
    // widths and strap bit positions
    localparam int unsigned MA_WIDTH = 13;
    localparam int unsigned BIT_MFG_TEST_N = 8;
    localparam int unsigned BIT_XBUS_SEL = 7;
    localparam int unsigned BIT_NORMAL_ROM = 6;
    localparam int unsigned BIT_ROM_WIDTH_HI = 5;
    localparam int unsigned BIT_ROM_WIDTH_LO = 4;
    localparam int unsigned BIT_CLASS_SEL = 3;
    localparam int unsigned BIT_OHOLD_N = 2;

    // ==========================================================
    // reset values and encodings
    localparam logic [12:0] STRAP_RESET_VAL = 13'h1fff;
    localparam logic [23:0] CLASS_CODE_ONE = 24'hb4_0001;
    localparam logic [23:0] CLASS_CODE_ZERO = 24'h0e_0001;
    localparam logic [1:0] ROMW_CODE_8 = 2'h3;
    localparam logic [1:0] ROMW_CODE_16 = 2'h1;
    localparam logic [1:0] ROMW_CODE_32 = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ROM_W8 = 2'b00,
        ROM_W16 = 2'b01,
        ROM_W32 = 2'b10,
        ROM_WRSV = 2'b11
    } rom_width_t;

    typedef struct packed {
        logic mfg_test_en;
        logic arbiter_sel;
        logic blank_rom_mode;
        rom_width_t rom_width;
        logic [23:0] class_code;
        logic ohold_test_en;
    } strap_cfg_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_RUN = 2'b10
    } strap_state_t;

endpackage : strap_pkg

// [strap_sync.sv]
// two-flop synchroniser for the strap pins and host reset
`timescale 1ns/1ns
module strap_sync
    import strap_pkg::*;
#(
    parameter int unsigned WIDTH = 14,
    parameter logic IDLE_VAL = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // ==========================================================
    // per-bit synchroniser, idles at the chosen reset level
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_r[gi] <= IDLE_VAL;
                    sync_o[gi] <= IDLE_VAL;
                end else begin
                    meta_r[gi] <= async_i[gi];
                    sync_o[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

endmodule : strap_sync
